// *** vreg_pkg.sv ***
// Shared constants, types and register layout of the voltage control block
package vreg_pkg;

  // Register offsets
  localparam logic [7:0] OFF_LOW_SEL = 8'h00;
  localparam logic [7:0] OFF_HIGH_SEL = 8'h01;
  localparam logic [7:0] OFF_CONTROL = 8'h02;
  localparam logic [7:0] OFF_ID_VENDOR = 8'h03;
  localparam logic [7:0] OFF_ID_REV = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h05;

  // Voltage register field positions
  localparam int SOFT_EN_BIT = 7;
  localparam int FPWM_BIT = 6;
  localparam int CODE_MSB = 5;
  localparam int CODE_W = 6;

  // Control register slew field position (bits 2:0)
  localparam int SLEW_MSB = 2;
  localparam int DISCH_BIT = 7;

  // Status register value while regulating
  localparam logic [7:0] STATUS_REGULATING = 8'h80;

  // Slave address (7-bit) and high-speed master code prefix
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h60;
  localparam logic [6:0] SLAVE_ADDR_ALT = 7'h62;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;

  // Option groups for the step formula
  localparam logic [2:0] OPT_BASE = 3'h0;
  localparam logic [2:0] OPT_12826 = 3'h1;
  localparam logic [2:0] OPT_RAISED = 3'h2;
  localparam logic [2:0] OPT_12500 = 3'h3;
  localparam logic [2:0] OPT_12967 = 3'h4;

  // Target voltage expressed in microvolts
  localparam int UV_BASE = 600000;
  localparam int UV_BASE_ALT = 603000;
  localparam int UV_RAISED = 800000;
  localparam int UV_STEP_10 = 10000;
  localparam int UV_STEP_12826 = 12826;
  localparam int UV_STEP_12500 = 12500;
  localparam int UV_STEP_12967 = 12967;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int RETRY_OFF_US = 1700;
  localparam int RETRY_OFF_CYC = RETRY_OFF_US * CLK_MHZ;
  localparam int CL_LIMIT = 16;
  localparam int SOFTSTART_CYC = 64;
  localparam int OV_FILTER_CYC = 16;
  // Fastest slew 64 mV/us over a 10 mV step: 15.625 cycles, held in eighths
  localparam int SLEW_STEP_X8 = 125;
  // Limit-free cycles that end a run of consecutive current limits
  localparam int CL_GAP_CYC = 24;

  // Reset values (base option defaults)
  localparam logic [7:0] RST_LOW_SEL = 8'had;
  localparam logic [7:0] RST_HIGH_SEL = 8'hfc;
  localparam logic [7:0] RST_CONTROL = 8'h80;

  // Fault and analog indications carried together
  typedef struct packed {
    logic supply_ok;
    logic overvoltage;
    logic over_temp;
    logic current_limit;
    logic out_reached;
  } analog_in_s;

  // Regulator command outputs carried together
  typedef struct packed {
    logic switching;
    logic forced_pwm;
    logic [CODE_W-1:0] voltage_code;
    logic [20:0] target_uv; // 21 bits: upper codes exceed 1.048 V
  } reg_cmd_s;

endpackage

// *** i2c_slave_port.sv ***
// Serial-bus slave: frames bytes, acknowledges and serves register access
`timescale 1ns/1ps
module i2c_slave_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [6:0] own_addr,
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  import vreg_pkg::*;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_BYTE = 6'b000010,
    S_ACK = 6'b000100,
    S_SEND = 6'b001000,
    S_MACK = 6'b010000,
    S_SKIP = 6'b100000
  } bus_state_e;

  // Three-stage synchronisers; decisions use stages two and three only
  logic [2:0] scl_sy, sda_sy, next_scl_sy, next_sda_sy;
  always_comb begin
    next_scl_sy = {scl_sy[1:0], scl_in};
    next_sda_sy = {sda_sy[1:0], sda_in};
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_sy <= 3'h7;
      sda_sy <= 3'h7;
    end else if (ce) begin
      scl_sy <= next_scl_sy;
      sda_sy <= next_sda_sy;
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_sy[1] & ~scl_sy[2];
  assign scl_fall = ~scl_sy[1] & scl_sy[2];
  assign start_c = scl_sy[1] & scl_sy[2] & ~sda_sy[1] & sda_sy[2];
  assign stop_c = scl_sy[1] & scl_sy[2] & sda_sy[1] & ~sda_sy[2];

  bus_state_e st, next_st;
  logic [7:0] sh, next_sh;
  logic [3:0] cnt, next_cnt;
  logic [1:0] phase, next_phase; // 0 addr, 1 reg addr, 2 data
  logic rd_mode, next_rd_mode;
  logic do_ack, next_do_ack;
  logic [7:0] ptr, next_ptr;
  logic next_sda_out, next_wr_stb;
  logic [7:0] next_wr_data;

  // Byte framing, acknowledge and read-data sequencing
  always_comb begin
    next_st = st;
    next_sh = sh;
    next_cnt = cnt;
    next_phase = phase;
    next_rd_mode = rd_mode;
    next_do_ack = do_ack;
    next_ptr = ptr;
    next_sda_out = sda_out;
    next_wr_stb = 1'b0;
    next_wr_data = wr_data;
    if (stop_c) begin
      next_st = S_IDLE;
      next_sda_out = 1'b1;
    end else if (start_c) begin
      // Repeated start also lands here; register pointer is kept
      next_st = S_BYTE;
      next_cnt = 4'h0;
      next_phase = 2'd0;
      next_sda_out = 1'b1;
    end else begin
      case (st)
        S_IDLE: next_sda_out = 1'b1;
        S_BYTE: if (scl_rise) begin
          next_sh = {sh[6:0], sda_sy[2]};
          next_cnt = cnt + 4'h1;
        end else if (scl_fall && cnt == 4'h8) begin
          next_cnt = 4'h0;
          next_st = S_ACK;
          next_do_ack = 1'b1;
          if (phase == 2'd0) begin
            next_do_ack = sh[7:1] == own_addr;
            next_rd_mode = sh[0];
            next_phase = 2'd1;
          end else if (phase == 2'd1) begin
            next_ptr = sh;
            next_phase = 2'd2;
          end else begin
            next_wr_stb = 1'b1;
            next_wr_data = sh;
          end
          next_sda_out = ~next_do_ack;
        end
        S_ACK: if (scl_fall) begin
          next_sda_out = 1'b1;
          if (!do_ack) begin
            next_st = S_SKIP;
          end else if (rd_mode && phase == 2'd1) begin
            next_st = S_SEND;
            next_sh = {rd_data[6:0], 1'b0};
            next_sda_out = rd_data[7];
            next_cnt = 4'h1;
          end else begin
            next_st = S_BYTE;
          end
        end
        S_SEND: if (scl_fall) begin
          if (cnt == 4'h8) begin
            next_sda_out = 1'b1;
            next_st = S_MACK;
          end else begin
            next_sda_out = sh[7];
            next_sh = {sh[6:0], 1'b0};
            next_cnt = cnt + 4'h1;
          end
        end
        S_MACK: if (scl_rise) begin
          // Master nack ends the read; an ack re-sends the same register
          next_st = sda_sy[2] ? S_SKIP : S_ACK;
          next_do_ack = ~sda_sy[2];
        end
        S_SKIP: next_sda_out = 1'b1;
        default: next_st = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= S_IDLE;
      sh <= 8'h00;
      cnt <= 4'h0;
      phase <= 2'd0;
      rd_mode <= 1'b0;
      do_ack <= 1'b0;
      ptr <= 8'h00;
      sda_out <= 1'b1;
      wr_stb <= 1'b0;
      wr_data <= 8'h00;
    end else if (ce) begin
      st <= next_st;
      sh <= next_sh;
      cnt <= next_cnt;
      phase <= next_phase;
      rd_mode <= next_rd_mode;
      do_ack <= next_do_ack;
      ptr <= next_ptr;
      sda_out <= next_sda_out;
      wr_stb <= next_wr_stb;
      wr_data <= next_wr_data;
    end
  end

  assign sda_oe = ~sda_out;
  assign wr_addr = ptr;
  assign rd_addr = ptr;

endmodule // i2c_slave_port

// *** vreg_control.sv ***
// Digital control of a programmable step-down regulator
`timescale 1ns/1ps
// Behaviour
// - Select pin low picks low-select register, high picks high-select.
// - Base group target is 0.60 V plus code times 10 mV.
// - Second group target is 0.603 V plus code times 12.826 mV.
// - Raised-base target is 0.80 V plus code times 10 mV.
// - 12.5 mV option target is 0.60 V plus code times 12.5 mV.
// - 12.967 mV option target is 0.603 V plus code times 12.967 mV.
// - Reset loads both voltage registers with their defaults.
// - Rising slew codes 0..5 give 64 down to 2 mV/us, halving.
// - Falling target stops switching until output reaches new point.
// - Non-10 mV options scale slew by step over 10 mV.
// - Filtered input overvoltage stops switching.
// - Power-ok low while disabled, faulted or soft-starting.
// - Power-ok stays high during bus-requested voltage changes.
// - Sixteen consecutive current limits shut down 1700 us, then retry.
// - Thermal shutdown stops switching until over-temperature clears.
// - Status register reads 80 hex when enabled and regulating.
// - SCL input only; SDA open drain, low only for data or ack.
// - All bytes travel most significant bit first.
// - Respond to address C0, or C4 for alternate option.
// - Sample SDA on SCL rise; change SDA while SCL low.
// - High-speed master code is never acknowledged.
// - Ack drives SDA low; nack leaves it high.
// - Voltage register: bit7 enable, bit6 forced PWM, bits5:0 code.
// - Output on when enable pin high and selected soft enable set.
module vreg_control #(
  parameter logic [2:0] OPTION = vreg_pkg::OPT_BASE,
  parameter logic ALT_ADDR = 1'b0,
  parameter int RETRY_CYC = vreg_pkg::RETRY_OFF_CYC,
  parameter logic [7:0] VENDOR_ID = 8'h5a, // Arbitrary value
  parameter logic [3:0] REV_ID = 4'h3 // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic enable_pin,
  input wire logic voltage_select_pin,
  input wire vreg_pkg::analog_in_s analog_in,
  output vreg_pkg::reg_cmd_s reg_cmd,
  output logic power_ok_output,
  output logic power_ok_oe
);
  import vreg_pkg::*;

  typedef enum logic [4:0] {
    P_OFF = 5'b00001,
    P_SOFT = 5'b00010,
    P_RUN = 5'b00100,
    P_FALL = 5'b01000,
    P_RETRY = 5'b10000
  } pwr_state_e;

  // Step size and base of the selected option, in microvolts
  function automatic logic [20:0] target_uv(input logic [5:0] code);
    int base;
    int step;
    base = UV_BASE;
    step = UV_STEP_10;
    case (OPTION)
      OPT_12826: begin base = UV_BASE_ALT; step = UV_STEP_12826; end
      OPT_RAISED: begin base = UV_RAISED; step = UV_STEP_10; end
      OPT_12500: begin base = UV_BASE; step = UV_STEP_12500; end
      OPT_12967: begin base = UV_BASE_ALT; step = UV_STEP_12967; end
      default: begin base = UV_BASE; step = UV_STEP_10; end
    endcase
    return 21'(base + int'(code) * step);
  endfunction

  // Timer load per code step; fixed step time scales mV/us by step size
  function automatic logic [15:0] slew_cycles(input logic [2:0] code);
    return 16'((((SLEW_STEP_X8 << code) + 4) >> 3) - 1); // Rounded period
  endfunction

  // Pin inputs pass three flip-flops; change seen when stages 2,3 agree
  logic [2:0] en_sy, vs_sy, ov_sy, ot_sy, cl_sy, ok_sy, rc_sy;
  logic en_q, vs_q, ov_q, ot_q, cl_q, ok_q, rc_q;
  logic next_en_q, next_vs_q, next_ov_q, next_ot_q, next_cl_q, next_ok_q;
  logic next_rc_q;
  always_comb begin
    next_en_q = (en_sy[1] == en_sy[2]) ? en_sy[2] : en_q;
    next_vs_q = (vs_sy[1] == vs_sy[2]) ? vs_sy[2] : vs_q;
    next_ov_q = (ov_sy[1] == ov_sy[2]) ? ov_sy[2] : ov_q;
    next_ot_q = (ot_sy[1] == ot_sy[2]) ? ot_sy[2] : ot_q;
    next_cl_q = (cl_sy[1] == cl_sy[2]) ? cl_sy[2] : cl_q;
    next_ok_q = (ok_sy[1] == ok_sy[2]) ? ok_sy[2] : ok_q;
    next_rc_q = (rc_sy[1] == rc_sy[2]) ? rc_sy[2] : rc_q;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      {en_sy, vs_sy, ov_sy, ot_sy, cl_sy, ok_sy, rc_sy} <= '0;
      {en_q, vs_q, ov_q, ot_q, cl_q, ok_q, rc_q} <= '0;
    end else if (ce) begin
      en_sy <= {en_sy[1:0], enable_pin};
      vs_sy <= {vs_sy[1:0], voltage_select_pin};
      ov_sy <= {ov_sy[1:0], analog_in.overvoltage};
      ot_sy <= {ot_sy[1:0], analog_in.over_temp};
      cl_sy <= {cl_sy[1:0], analog_in.current_limit};
      ok_sy <= {ok_sy[1:0], analog_in.supply_ok};
      rc_sy <= {rc_sy[1:0], analog_in.out_reached};
      en_q <= next_en_q;
      vs_q <= next_vs_q;
      ov_q <= next_ov_q;
      ot_q <= next_ot_q;
      cl_q <= next_cl_q;
      ok_q <= next_ok_q;
      rc_q <= next_rc_q;
    end
  end

  // Bus slave
  logic wr_stb;
  logic [7:0] wr_addr, wr_data, rd_addr;
  logic [7:0] rd_data;
  logic sda_out_c, sda_oe_c;
  i2c_slave_port u_bus (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out_c),
    .sda_oe(sda_oe_c),
    .own_addr(ALT_ADDR ? SLAVE_ADDR_ALT : SLAVE_ADDR_BASE),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Register file
  logic [7:0] low_select_voltage_reg, high_select_voltage_reg, control;
  logic [7:0] regulation_status;
  logic [7:0] next_low, next_high, next_control;
  always_comb begin
    next_low = low_select_voltage_reg;
    next_high = high_select_voltage_reg;
    next_control = control;
    if (wr_stb) begin
      case (wr_addr)
        OFF_LOW_SEL: next_low = wr_data;
        OFF_HIGH_SEL: next_high = wr_data;
        OFF_CONTROL: next_control = wr_data;
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      low_select_voltage_reg <= RST_LOW_SEL;
      high_select_voltage_reg <= RST_HIGH_SEL;
      control <= RST_CONTROL;
    end else if (ce) begin
      low_select_voltage_reg <= next_low;
      high_select_voltage_reg <= next_high;
      control <= next_control;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (rd_addr)
      OFF_LOW_SEL: rd_data = low_select_voltage_reg;
      OFF_HIGH_SEL: rd_data = high_select_voltage_reg;
      OFF_CONTROL: rd_data = control;
      OFF_ID_VENDOR: rd_data = VENDOR_ID;
      OFF_ID_REV: rd_data = {4'h0, REV_ID};
      OFF_STATUS: rd_data = regulation_status;
      default: rd_data = 8'h00;
    endcase
  end

  logic [7:0] sel_reg;
  assign sel_reg = vs_q ? high_select_voltage_reg : low_select_voltage_reg;

  // Overvoltage filter: only a steady indication causes shutdown
  logic [4:0] ov_cnt, next_ov_cnt;
  logic ov_trip;
  always_comb begin
    if (!ov_q) begin
      next_ov_cnt = 5'h0;
    end else if (ov_cnt != 5'(OV_FILTER_CYC)) begin
      next_ov_cnt = ov_cnt + 5'h1;
    end else begin
      next_ov_cnt = ov_cnt;
    end
  end
  assign ov_trip = ov_cnt == 5'(OV_FILTER_CYC);

  // Power sequencing
  pwr_state_e ps, next_ps;
  logic [5:0] cur_code, next_cur_code;
  logic [23:0] tmr, next_tmr;
  logic [4:0] cl_cnt, next_cl_cnt, cl_gap, next_cl_gap;
  logic cl_d, next_cl_d;
  logic want_on, fault;
  logic next_pok, next_sw;
  assign want_on = en_q & sel_reg[SOFT_EN_BIT];
  assign fault = ov_trip | ot_q | ~ok_q;

  always_comb begin
    next_ps = ps;
    next_cur_code = cur_code;
    next_tmr = tmr;
    next_cl_cnt = cl_cnt;
    next_cl_d = cl_q;
    next_cl_gap = cl_q ? 5'h0 : cl_gap + 5'(cl_gap != 5'(CL_GAP_CYC));
    next_pok = 1'b0;
    next_sw = 1'b0;
    if (ps == P_RUN || ps == P_SOFT) begin
      if (cl_q && !cl_d) begin
        next_cl_cnt = cl_cnt + 5'h1;
      end else if (cl_gap == 5'(CL_GAP_CYC)) begin // Run broken
        next_cl_cnt = 5'h0;
      end
    end
    if (!want_on || fault) begin
      next_ps = (ps == P_RETRY) ? P_RETRY : P_OFF;
      next_cl_cnt = 5'h0;
    end
    case (ps)
      P_OFF: if (want_on && !fault) begin
        next_ps = P_SOFT;
        next_tmr = 24'(SOFTSTART_CYC);
        next_cur_code = sel_reg[CODE_MSB:0];
      end
      P_SOFT: begin
        next_sw = 1'b1;
        if (tmr != 24'h0) begin
          next_tmr = tmr - 24'h1;
        end else if (next_ps == P_SOFT) begin
          next_ps = P_RUN;
        end
      end
      P_RUN: begin
        next_sw = 1'b1;
        next_pok = 1'b1;
        if (tmr != 24'h0) begin
          next_tmr = tmr - 24'h1;
        end else if (sel_reg[CODE_MSB:0] > cur_code) begin
          next_cur_code = cur_code + 6'h1;
          next_tmr = 24'(slew_cycles(control[SLEW_MSB:0]));
        end else if (sel_reg[CODE_MSB:0] < cur_code) begin
          next_cur_code = sel_reg[CODE_MSB:0];
          if (next_ps == P_RUN) next_ps = P_FALL;
        end
      end
      P_FALL: begin
        next_pok = 1'b1;
        if (rc_q && next_ps == P_FALL) next_ps = P_RUN;
      end
      P_RETRY: begin
        if (tmr != 24'h0) begin
          next_tmr = tmr - 24'h1;
        end else begin
          next_ps = P_OFF;
        end
      end
      default: next_ps = P_OFF;
    endcase
    if (next_cl_cnt == 5'(CL_LIMIT) && ps != P_RETRY) begin
      next_ps = P_RETRY;
      next_tmr = 24'(RETRY_CYC);
      next_cl_cnt = 5'h0;
      next_sw = 1'b0;
      next_pok = 1'b0;
    end
    if (next_ps != P_RUN && next_ps != P_FALL) next_pok = 1'b0;
    if (next_ps != P_RUN && next_ps != P_SOFT) next_sw = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ps <= P_OFF;
      cur_code <= 6'h0;
      tmr <= 24'h0;
      cl_cnt <= 5'h0;
      cl_d <= 1'b0;
      cl_gap <= 5'h0;
      ov_cnt <= 5'h0;
      power_ok_output <= 1'b0;
      power_ok_oe <= 1'b1;
      reg_cmd <= '0;
      regulation_status <= 8'h00;
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
    end else if (ce) begin
      ps <= next_ps;
      cur_code <= next_cur_code;
      tmr <= next_tmr;
      cl_cnt <= next_cl_cnt;
      cl_d <= next_cl_d;
      cl_gap <= next_cl_gap;
      ov_cnt <= next_ov_cnt;
      // Open drain: drive low only, release when good
      power_ok_output <= 1'b0;
      power_ok_oe <= ~next_pok;
      reg_cmd.switching <= next_sw;
      reg_cmd.forced_pwm <= sel_reg[FPWM_BIT];
      reg_cmd.voltage_code <= next_cur_code;
      reg_cmd.target_uv <= target_uv(next_cur_code);
      regulation_status <= (next_ps == P_RUN || next_ps == P_FALL) ?
        STATUS_REGULATING : 8'h00;
      sda_out <= sda_out_c;
      sda_oe <= sda_oe_c;
    end
  end

endmodule // vreg_control

// *** vreg_control_checker.sv ***
// Concurrent checks on the regulator control ports
`timescale 1ns/1ps
module vreg_control_checker
  import vreg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic enable_pin,
  input wire vreg_pkg::analog_in_s analog_in,
  input wire vreg_pkg::reg_cmd_s reg_cmd,
  input wire logic power_ok_output,
  input wire logic power_ok_oe
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_sda_pull_low: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  a_pok_drive_low: assert property (power_ok_output == 1'b0)
    else $error("power ok driven high");
  a_ack_launch_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data drive began with clock high");
  a_hold_clk_high: assert property (
    scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data drive changed with clock high");
  a_pok_pin_off: assert property (!enable_pin [*6] |=> power_ok_oe)
    else $error("power ok released while pin low");
  a_sw_pin_off: assert property (
    !enable_pin [*6] |=> !reg_cmd.switching)
    else $error("switching while pin low");
  a_thermal_stop: assert property (
    analog_in.over_temp [*6] |=> !reg_cmd.switching)
    else $error("switching while over temperature");
  // filtered overvoltage; longer than sync plus filter
  a_ov_stop: assert property (
    analog_in.overvoltage [*8] ##1 analog_in.overvoltage [*8]
    ##1 analog_in.overvoltage [*8] |=> !reg_cmd.switching)
    else $error("switching during long overvoltage");
  // base step formula, checked only while regulating
  a_target_base: assert property (
    reg_cmd.switching && !power_ok_oe |->
    reg_cmd.target_uv == 21'(UV_BASE + UV_STEP_10 * reg_cmd.voltage_code))
    else $error("target does not follow code");

  // Main scenarios reached
  c_ack: cover property ($rose(sda_oe));
  c_stop: cover property ($fell(reg_cmd.switching));
  c_pok: cover property ($fell(power_ok_oe));
endmodule // vreg_control_checker

bind vreg_control vreg_control_checker i_vreg_control_checker (
  .clk(clk), .rst(rst), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .enable_pin(enable_pin), .analog_in(analog_in),
  .reg_cmd(reg_cmd), .power_ok_output(power_ok_output),
  .power_ok_oe(power_ok_oe));

// *** vreg_bus_master.sv ***
// Serial bus master model that reads and writes regulator registers
`timescale 1ns/1ps
module vreg_bus_master (
  input wire logic clk,
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  int half = 8; // Clock half period in cycles; raise it to run slow

  // Idle bus: both lines released high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Wait, then step just past the edge
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // start or repeated start: data falls with clock high
  task automatic start();
    sda_drv = 1'b1;
    w(half);
    scl = 1'b1;
    w(half);
    sda_drv = 1'b0;
    w(half);
    scl = 1'b0;
  endtask

  // stop: data rises with clock high
  task automatic stop();
    w(2);
    sda_drv = 1'b0;
    w(half);
    scl = 1'b1;
    w(half);
    sda_drv = 1'b1;
    w(half);
  endtask

  // change with clock low, sample at end of high phase
  task automatic bit_io(input logic b, output logic r);
    w(2);
    sda_drv = b;
    w(half);
    scl = 1'b1;
    w(half);
    r = sda;
    scl = 1'b0;
  endtask

  // eight bits most significant first, then the ack slot
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx,
                         output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(1'b1, ack);
  endtask

  // write: address, register, data; zero ack bits mean taken
  task automatic wr(input logic [7:0] dev, input logic [7:0] ra,
                    input logic [7:0] dv, output logic [2:0] acks);
    logic [7:0] rx;
    start();
    byte_io(dev, rx, acks[2]);
    byte_io(ra, rx, acks[1]);
    byte_io(dv, rx, acks[0]);
    stop();
  endtask

  // read: register, repeated start, read address, nack, stop
  task automatic rd(input logic [7:0] ra, output logic [7:0] dv,
                    output logic [2:0] acks);
    logic nack;
    start();
    byte_io(8'hc0, dv, acks[2]);
    byte_io(ra, dv, acks[1]);
    start();
    byte_io(8'hc1, dv, acks[0]);
    byte_io(8'hff, dv, nack);
    stop();
  endtask
endmodule // vreg_bus_master

// *** tb_vreg_control.sv ***
// Self-checking bench for the regulator control block
`timescale 1ns/1ps
module tb_vreg_control;
  import vreg_pkg::*;
  localparam int RETRY = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl;
  logic sda_drv;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic enable_pin = 1'b0;
  logic voltage_select_pin = 1'b0;
  analog_in_s analog_in = 5'h10; // Supply good, no faults
  reg_cmd_s reg_cmd;
  logic power_ok_output;
  logic power_ok_oe;
  logic [7:0] d;
  logic [2:0] a;
  int n_mismatch = 0;
  int n_checks = 0;

  // 100 MHz clock
  always #5 clk = ~clk;
  // Pull-up on the shared data line
  assign sda = sda_drv & (sda_oe ? sda_out : 1'b1);

  vreg_control #(.RETRY_CYC(RETRY)) i_vreg_control (
    .clk(clk), .rst(rst), .ce(1'b1), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .enable_pin(enable_pin),
    .voltage_select_pin(voltage_select_pin), .analog_in(analog_in),
    .reg_cmd(reg_cmd), .power_ok_output(power_ok_output),
    .power_ok_oe(power_ok_oe));
  vreg_bus_master m (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda(sda));

  // Counts and verdict; the only way the run ends
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [20:0] e,
                     input logic [20:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait on switching (k 0) or power ok pull (k 1)
  task automatic wait_on(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while ((k == 0 ? reg_cmd.switching : power_ok_oe) !== v) begin
      cyc(1);
      n++;
      if (n > lim) begin
        chk("wait_on", v, ~v);
        report_and_stop();
      end
    end
  endtask

  // Rising ramp; power ok must stay released throughout
  task automatic ramp(input logic [5:0] goal, input int lo, input int hi);
    int n;
    n = 0;
    while (reg_cmd.voltage_code !== goal && n <= hi) begin
      cyc(1);
      n++;
      if (power_ok_oe !== 1'b0) chk("pok_ramp", 0, 1);
    end
    chk("ramp_time", 1, n > lo && n <= hi);
    if (n > hi) report_and_stop();
  endtask

  task automatic t_regs();
    m.half = 20; // Slow master once
    m.rd(OFF_LOW_SEL, d, a);
    m.half = 8;
    chk("ack", 0, a);
    chk("low_sel", RST_LOW_SEL, d);
    m.rd(OFF_HIGH_SEL, d, a);
    chk("high_sel", RST_HIGH_SEL, d);
    m.rd(OFF_CONTROL, d, a);
    chk("control", RST_CONTROL, d);
    m.wr(8'hc4, OFF_HIGH_SEL, 8'h00, a);
    chk("alt_nack", 3'b111, a);
    m.wr(8'h09, OFF_HIGH_SEL, 8'h00, a);
    chk("hs_nack", 3'b111, a);
    m.wr(8'hc0, OFF_STATUS, 8'h55, a);
    m.rd(OFF_STATUS, d, a);
    chk("status_ro", 0, d);
    m.rd(8'h3f, d, a);
    chk("unmapped", 0, d);
    m.wr(8'hc0, OFF_LOW_SEL, 8'h9f, a);
    chk("wr_ack", 0, a);
    m.rd(OFF_LOW_SEL, d, a);
    chk("low_sel", 8'h9f, d);
    m.rd(OFF_HIGH_SEL, d, a);
    chk("high_sel", RST_HIGH_SEL, d);
    $display("test regs done");
  endtask

  task automatic t_dvs();
    enable_pin = 1'b1;
    wait_on(1, 1'b0, 500);
    chk("code_low", 6'h1f, reg_cmd.voltage_code);
    chk("fpwm", 0, reg_cmd.forced_pwm);
    chk("target", 21'd910000, reg_cmd.target_uv);
    m.rd(OFF_STATUS, d, a);
    chk("status", STATUS_REGULATING, d);
    voltage_select_pin = 1'b1;
    ramp(6'h3c, 28 * SLEW_STEP_X8 / 8, 29 * SLEW_STEP_X8 / 8 + 300);
    voltage_select_pin = 1'b0;
    wait_on(0, 1'b0, 20);
    cyc(100);
    chk("fall_hold", 0, reg_cmd.switching);
    analog_in.out_reached = 1'b1;
    wait_on(0, 1'b1, 20);
    analog_in.out_reached = 1'b0;
    m.wr(8'hc0, OFF_CONTROL, 8'h87, a);
    m.wr(8'hc0, OFF_LOW_SEL, 8'he1, a);
    ramp(6'h21, (SLEW_STEP_X8 << 4) - 200, SLEW_STEP_X8 << 4);
    chk("fpwm", 1, reg_cmd.forced_pwm);
    $display("test dvs done");
  endtask

  // Fault raised then cleared; switching must stop and recover
  task automatic fault(input int k);
    analog_in[k] = ~analog_in[k];
    wait_on(0, 1'b0, 60);
    chk("pok_fault", 1, power_ok_oe);
    cyc(10); // Hold long enough for the overvoltage check to engage
    analog_in[k] = ~analog_in[k];
    wait_on(1, 1'b0, 500);
  endtask

  task automatic t_faults();
    analog_in.overvoltage = 1'b1;
    cyc(3);
    analog_in.overvoltage = 1'b0;
    cyc(30);
    chk("ov_spike", 1, reg_cmd.switching);
    fault(4);
    fault(3);
    fault(2);
    repeat (16) begin
      analog_in.current_limit = 1'b1;
      cyc(4);
      analog_in.current_limit = 1'b0;
      cyc(4);
    end
    wait_on(0, 1'b0, 40);
    cyc(RETRY - 20);
    chk("retry_off", 0, reg_cmd.switching);
    wait_on(0, 1'b1, 300);
    m.wr(8'hc0, OFF_LOW_SEL, 8'h61, a);
    wait_on(1, 1'b1, 40);
    m.rd(OFF_STATUS, d, a);
    chk("status_off", 0, d);
    enable_pin = 1'b0;
    cyc(10);
    $display("test faults done");
  endtask

  // Reset for four cycles, then the scenarios in order
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    cyc(4);
    t_regs();
    t_dvs();
    t_faults();
    report_and_stop();
  end
endmodule // tb_vreg_control
